// ### rtl/iovf_pkg.sv
// Purpose: constants and state codes for input over-voltage fault handling
// Assumes: command codes arrive already decoded from the management bus
// Notes:   field positions follow the fault action register layout
package iovf_pkg;
	// command codes
	localparam logic [7:0]  CMD_THRESHOLD     = 8'h55;
	localparam logic [7:0]  CMD_ACTION        = 8'h56;
	// fault action register fields
	localparam int          ACT_RESP_HI       = 7;
	localparam int          ACT_RESP_LO       = 6;
	localparam int          ACT_RETRY_HI      = 5;
	localparam int          ACT_RETRY_LO      = 3;
	localparam int          ACT_DELAY_HI      = 2;
	localparam int          ACT_DELAY_LO      = 0;
	// response select codes
	localparam logic [1:0]  RESP_IGNORE       = 2'h0;
	localparam logic [1:0]  RESP_CONTINUE     = 2'h1;
	localparam logic [1:0]  RESP_DISABLE      = 2'h2;
	localparam logic [1:0]  RESP_LATCH        = 2'h3;
	// retry codes
	localparam logic [2:0]  RETRY_NONE        = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER     = 3'h7;
	// reset values
	localparam logic [15:0] THRESHOLD_RESET   = 16'hFFFF;
	localparam logic [7:0]  ACTION_RESET      = 8'h80;
	// delay unit counter
	localparam logic [7:0]  UNITS_ONE         = 8'h01;

	typedef enum logic [4:0] {
		ST_RUN     = 5'h01,
		ST_CONT    = 5'h02,
		ST_OFFWAIT = 5'h04,
		ST_RESTART = 5'h08,
		ST_LATCHED = 5'h10
	} iovf_state_t;
endpackage

// ### rtl/iovf_delay_timer.sv
// Purpose: counts 2^code time-unit ticks after a start pulse
// Assumes: unitTick is one clock wide, one per configured time unit
// Notes:   a new start abandons any count in progress
`timescale 1ns/1ps
module iovf_delay_timer (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       start,
	input  wire logic [2:0] code,
	input  wire logic       unitTick,
	// result
	output logic            done
);
	logic [7:0] remQ;
	logic       runQ;
	logic       doneQ;
	wire  [7:0] loadUnits = iovf_pkg::UNITS_ONE << code;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			remQ  <= 8'h00;
			runQ  <= 1'b0;
			doneQ <= 1'b0;
		end else if (start) begin
			remQ  <= loadUnits; // [R10]
			runQ  <= 1'b1;
			doneQ <= 1'b0;
		end else if (runQ && unitTick) begin
			if (remQ == iovf_pkg::UNITS_ONE) begin
				runQ  <= 1'b0;
				doneQ <= 1'b1;
			end else begin
				remQ  <= remQ - 8'h01;
			end
		end else begin
			doneQ <= 1'b0;
		end
	end

	assign done = doneQ;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_short_start;
		(start && code == 3'h0) ##1 (!start && unitTick);
	endsequence

	a_unit_single: assert property (s_short_start |=> done) // [R10]
		else $error("one-unit delay did not end after one tick");
	a_unit_eight: assert property (
		(start && code == 3'h3) |=> (!done)[*8]) // [R10]
		else $error("eight-unit delay ended too early");
endmodule

// ### rtl/iovf_fault_response.sv
// Purpose: input over-voltage detection and programmable fault response
// Assumes: vinMeas uses the same encoding as the stored threshold
// Notes:   time unit comes in as unitTick; output enable is the result
// Functional notes
// R1: threshold is 16-bit, read/write at 0x55
// R2: response 00 keeps output running
// R3: response 01 runs for delay, then retries
// R4: response 10 disables at once, then retries
// R5: response 11 latches off until cleared
// R6: retry 000 means stay off
// R7: retry 001 tries one restart, then latch
// R8: retry 010 tries two restarts, then latch
// R9: restart spacing equals delay times time unit
// R10: delay code n means 2^n time units
// R11: retry 111 retries forever until commanded off
// R12: fault when input exceeds programmed threshold
`timescale 1ns/1ps
module iovf_fault_response (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// command port
	input  wire logic        cmdWrite,
	input  wire logic        cmdRead,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [15:0] cmdWrData,
	output logic      [15:0] cmdRdData,
	output logic             cmdRdValid,
	// fault clearing and control
	input  wire logic        statusClear,
	input  wire logic        clearFaults,
	input  wire logic        outputOnCmd,
	// measurement and timing
	input  wire logic [15:0] vinMeas,
	input  wire logic        unitTick,
	// results
	output logic             outputEnable,
	output logic             faultStatus
);
	logic                    rstMeta_q;
	logic                    rstSync_q;
	logic [15:0]             threshold_q;
	logic [7:0]              action_q;
	logic [15:0]             rdData_q;
	logic                    rdValid_q;
	logic                    status_q;
	logic                    outEn_q;
	logic [2:0]              attempts_q;
	logic [2:0]              attempts_d;
	iovf_pkg::iovf_state_t   state_q;
	iovf_pkg::iovf_state_t   state_d;
	logic                    timerDone;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// command decode
	wire wrThreshold = cmdWrite && (cmdCode == iovf_pkg::CMD_THRESHOLD);
	wire wrAction    = cmdWrite && (cmdCode == iovf_pkg::CMD_ACTION);
	wire [15:0] rdMux =
		(cmdCode == iovf_pkg::CMD_THRESHOLD) ? threshold_q :
		(cmdCode == iovf_pkg::CMD_ACTION)    ? {8'h00, action_q} :
		16'h0000;

	// action fields
	wire [1:0] respSel  = action_q[iovf_pkg::ACT_RESP_HI:iovf_pkg::ACT_RESP_LO];
	wire [2:0] retryLim =
		action_q[iovf_pkg::ACT_RETRY_HI:iovf_pkg::ACT_RETRY_LO];
	wire [2:0] delayCode =
		action_q[iovf_pkg::ACT_DELAY_HI:iovf_pkg::ACT_DELAY_LO];

	wire faultNow   = vinMeas > threshold_q; // [R12]
	wire clearAny   = statusClear || clearFaults || !outputOnCmd; // [R5]
	// a further restart is allowed while under the limit or unlimited
	wire moreRetry  = (retryLim == iovf_pkg::RETRY_FOREVER) ||
		(attempts_q < retryLim); // [R7] [R8] [R11]
	wire firstRetry = retryLim != iovf_pkg::RETRY_NONE; // [R6]

	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			threshold_q <= iovf_pkg::THRESHOLD_RESET;
			action_q    <= iovf_pkg::ACTION_RESET;
		end else begin
			if (wrThreshold)
				threshold_q <= cmdWrData; // [R1]
			if (wrAction)
				action_q    <= cmdWrData[7:0];
		end
	end

	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			rdData_q  <= 16'h0000;
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= cmdRead;
			if (cmdRead)
				rdData_q <= rdMux; // [R1]
		end
	end

	// sticky fault bit: a new fault wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q)
			status_q <= 1'b0;
		else if (faultNow)
			status_q <= 1'b1; // [R12]
		else if (statusClear || clearFaults)
			status_q <= 1'b0;
	end

	// response sequencing
	always_comb begin
		state_d    = state_q;
		attempts_d = attempts_q;
		unique case (state_q)
			iovf_pkg::ST_RUN: begin
				attempts_d = 3'h0;
				if (faultNow && outputOnCmd) begin
					unique case (respSel)
						iovf_pkg::RESP_IGNORE:   state_d = iovf_pkg::ST_RUN; // [R2]
						iovf_pkg::RESP_CONTINUE: state_d = iovf_pkg::ST_CONT; // [R3]
						iovf_pkg::RESP_DISABLE:  state_d = firstRetry ?
							iovf_pkg::ST_OFFWAIT : iovf_pkg::ST_LATCHED; // [R4] [R6]
						iovf_pkg::RESP_LATCH:    state_d = iovf_pkg::ST_LATCHED; // [R5]
					endcase
				end
			end
			iovf_pkg::ST_CONT: begin
				if (!outputOnCmd)
					state_d = iovf_pkg::ST_RUN;
				else if (timerDone)
					// still faulty at the end of the delay: use retry setting
					state_d = !faultNow ? iovf_pkg::ST_RUN :
						firstRetry ? iovf_pkg::ST_OFFWAIT :
						iovf_pkg::ST_LATCHED; // [R3]
			end
			iovf_pkg::ST_OFFWAIT: begin
				if (!outputOnCmd) begin
					state_d = iovf_pkg::ST_RUN;
				end else if (timerDone) begin
					state_d    = iovf_pkg::ST_RESTART; // [R9]
					attempts_d = attempts_q + 3'h1;
				end
			end
			iovf_pkg::ST_RESTART: begin
				if (!outputOnCmd)
					state_d = iovf_pkg::ST_RUN; // [R11]
				else if (faultNow)
					state_d = moreRetry ? iovf_pkg::ST_OFFWAIT :
						iovf_pkg::ST_LATCHED; // [R7] [R8] [R11]
				else if (timerDone)
					state_d = iovf_pkg::ST_RUN;
			end
			iovf_pkg::ST_LATCHED: begin
				if (clearAny)
					state_d = iovf_pkg::ST_RUN; // [R5] [R6]
			end
			default: state_d = iovf_pkg::ST_LATCHED;
		endcase
	end

	// restart after a fault-free attempt window; timer restarts on entry
	wire timerStart = (state_d != state_q) &&
		(state_d == iovf_pkg::ST_CONT || state_d == iovf_pkg::ST_OFFWAIT ||
		 state_d == iovf_pkg::ST_RESTART); // [R9]
	wire outEnD = outputOnCmd && (state_d != iovf_pkg::ST_OFFWAIT) &&
		(state_d != iovf_pkg::ST_LATCHED); // [R4] [R5]

	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q    <= iovf_pkg::ST_RUN;
			attempts_q <= 3'h0;
			outEn_q    <= 1'b0;
		end else begin
			state_q    <= state_d;
			attempts_q <= attempts_d;
			outEn_q    <= outEnD;
		end
	end

	iovf_delay_timer u_timer (
		.clk      (clk),
		.rst_n    (rstSync_q),
		.start    (timerStart),
		.code     (delayCode),
		.unitTick (unitTick),
		.done     (timerDone)
	);

	assign cmdRdData    = rdData_q;
	assign cmdRdValid   = rdValid_q;
	assign outputEnable = outEn_q;
	assign faultStatus  = status_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_q);

	sequence s_fault_in_run(logic [1:0] r);
		state_q == iovf_pkg::ST_RUN && faultNow && outputOnCmd && respSel == r;
	endsequence

	a_threshold_write: assert property (wrThreshold
		|=> threshold_q == $past(cmdWrData)) // [R1]
		else $error("threshold write not stored");
	a_ignore_runs: assert property (s_fault_in_run(iovf_pkg::RESP_IGNORE)
		|=> state_q == iovf_pkg::ST_RUN ##0 outputEnable) // [R2]
		else $error("ignore mode interrupted output");
	a_continue_on: assert property (s_fault_in_run(iovf_pkg::RESP_CONTINUE)
		|=> state_q == iovf_pkg::ST_CONT && outputEnable) // [R3]
		else $error("continue mode dropped output");
	a_disable_now: assert property (s_fault_in_run(iovf_pkg::RESP_DISABLE)
		|=> !outputEnable) // [R4]
		else $error("disable mode kept output on");
	a_latch_holds: assert property (state_q == iovf_pkg::ST_LATCHED
		&& !clearAny |=> state_q == iovf_pkg::ST_LATCHED && !outputEnable) // [R5]
		else $error("latched off left without clear");
	a_no_retry: assert property (s_fault_in_run(iovf_pkg::RESP_DISABLE)
		&& retryLim == iovf_pkg::RETRY_NONE
		|=> state_q == iovf_pkg::ST_LATCHED) // [R6]
		else $error("retry none did not latch");
	a_retry_spent: assert property (state_q == iovf_pkg::ST_RESTART
		&& outputOnCmd && faultNow && retryLim != iovf_pkg::RETRY_FOREVER
		&& attempts_q >= retryLim |=> state_q == iovf_pkg::ST_LATCHED) // [R7] [R8]
		else $error("retries exhausted but not latched");
	a_restart_spacing: assert property (state_q == iovf_pkg::ST_OFFWAIT
		&& outputOnCmd && timerDone |=> state_q == iovf_pkg::ST_RESTART) // [R9]
		else $error("restart not begun at delay end");
	a_retry_forever: assert property (state_q == iovf_pkg::ST_RESTART
		&& outputOnCmd && faultNow && retryLim == iovf_pkg::RETRY_FOREVER
		|=> state_q == iovf_pkg::ST_OFFWAIT) // [R11]
		else $error("unlimited retry stopped");
	a_fault_flag: assert property (faultNow |=> faultStatus) // [R12]
		else $error("fault not flagged");
endmodule

// ### sim/iovf_host_model.sv
// Purpose: host side model: command strobes and time-unit ticks
// Assumes: device samples commands on rising clock edges
// Notes:   released write data is inverted so stale values show
`timescale 1ns/1ps
module iovf_host_model #(
	parameter int TICK_DIV = 8
) (
	// clock
	input  wire logic        clk,
	// command port
	output logic             cmdWrite,
	output logic             cmdRead,
	output logic      [7:0]  cmdCode,
	output logic      [15:0] cmdWrData,
	input  wire logic [15:0] cmdRdData,
	input  wire logic        cmdRdValid,
	// time unit
	output logic             unitTick
);
	int div = 0;
	initial begin
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdCode = 8'h00;
		cmdWrData = 16'h0000;
		unitTick = 1'b0;
	end
	always @(negedge clk) begin
		div <= (div == TICK_DIV - 1) ? 0 : div + 1;
		unitTick <= (div == TICK_DIV - 1);
	end
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmdCode = c;
		cmdWrData = d;
		cmdWrite = 1'b1;
		@(negedge clk);
		cmdWrite = 1'b0;
		cmdWrData = ~d;
	endtask
	// read data is only valid in the cycle after the strobe is taken
	task automatic rd(input logic [7:0] c, output logic [15:0] d,
		output logic v);
		@(negedge clk);
		cmdCode = c;
		cmdRead = 1'b1;
		@(negedge clk);
		cmdRead = 1'b0;
		v = cmdRdValid;
		d = cmdRdData;
	endtask
endmodule

// ### sim/tb.sv
// Purpose: self-checking bench for input over-voltage fault response
// Assumes: host model supplies commands and time-unit ticks
// Notes:   threshold 0x1000; faults drive one code above it
`timescale 1ns/1ps
module tb;
	localparam int TDIV = 8;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        statusClear = 1'b0;
	logic        clearFaults = 1'b0;
	logic        outputOnCmd = 1'b0;
	logic        oePrev = 1'b0;
	logic [15:0] vinMeas = 16'h0000;
	logic        cmdWrite, cmdRead, cmdRdValid, unitTick, v;
	logic        outputEnable, faultStatus;
	logic [7:0]  cmdCode;
	logic [15:0] cmdWrData, cmdRdData, d;
	int          failCount = 0, testsRun = 0, cycles = 0;
	int          rises = 0, ticks = 0, gap = 0;
	always #2 clk = ~clk;
	iovf_host_model #(.TICK_DIV(TDIV)) host (.clk(clk), .cmdWrite(cmdWrite),
		.cmdRead(cmdRead), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
		.cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .unitTick(unitTick));
	iovf_fault_response DUT (.clk(clk), .rst_n(rst_n), .cmdWrite(cmdWrite),
		.cmdRead(cmdRead), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
		.cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid),
		.statusClear(statusClear), .clearFaults(clearFaults),
		.outputOnCmd(outputOnCmd), .vinMeas(vinMeas), .unitTick(unitTick),
		.outputEnable(outputEnable), .faultStatus(faultStatus));
	// restart count and tick spacing, sampled after outputs settle
	always @(posedge clk) begin
		#1;
		cycles++;
		if (outputEnable === 1'b1 && oePrev !== 1'b1) begin
			rises++;
			gap = ticks;
			ticks = 0;
		end
		if (unitTick === 1'b1)
			ticks++;
		oePrev = outputEnable;
		if (cycles == 20000) begin
			failCount++;
			completeRun();
		end
	end
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		testsRun++;
		if (g !== e) begin
			failCount++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkBit(input string n, input logic e, input logic g);
		chk(n, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic rdChk(input logic [7:0] c, input logic [15:0] e);
		host.rd(c, d, v);
		chkBit("rdValid", 1'b1, v);
		chk("rdData", e, d);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic setv(input logic [15:0] x);
		@(negedge clk);
		vinMeas = x;
	endtask
	// one-cycle pulse on either clear input
	task automatic clr(input logic all);
		@(negedge clk);
		clearFaults = all;
		statusClear = ~all;
		@(negedge clk);
		clearFaults = 1'b0;
		statusClear = 1'b0;
	endtask
	task automatic completeRun();
		$display("checks %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		cyc(5);
		rst_n = 1'b1;
		cyc(4);
		rdChk(8'h55, 16'hFFFF);
		rdChk(8'h56, 16'h0080);
		rdChk(8'h57, 16'h0000);
		host.wr(8'h55, 16'h1000);
		host.wr(8'h56, 16'hFF00);
		rdChk(8'h55, 16'h1000);
		rdChk(8'h56, 16'h0000);
		outputOnCmd = 1'b1;
		setv(16'h1000);
		cyc(6);
		chkBit("equalNoFault", 1'b0, faultStatus);
		setv(16'h1001);
		cyc(6);
		chkBit("aboveFault", 1'b1, faultStatus);
		chkBit("ignoreOn", 1'b1, outputEnable);
		host.wr(8'h56, 16'h00C0);
		cyc(3);
		chkBit("latchOff", 1'b0, outputEnable);
		setv(16'h0FFF);
		cyc(100);
		chkBit("latchHeld", 1'b0, outputEnable);
		clr(1'b1);
		cyc(3);
		chkBit("clearFaultsOn", 1'b1, outputEnable);
		chkBit("statusCleared", 1'b0, faultStatus);
		setv(16'h1001);
		setv(16'h0FFF);
		cyc(3);
		outputOnCmd = 1'b0;
		cyc(2);
		outputOnCmd = 1'b1;
		cyc(3);
		chkBit("offOnRestores", 1'b1, outputEnable);
		host.wr(8'h56, 16'h0080);
		setv(16'h1001);
		setv(16'h0FFF);
		cyc(2);
		chkBit("disableSoon", 1'b0, outputEnable);
		cyc(100);
		chkBit("noRetryOff", 1'b0, outputEnable);
		clr(1'b0);
		cyc(3);
		chkBit("statusClrOn", 1'b1, outputEnable);
		for (int r = 1; r <= 3; r++) begin
			host.wr(8'h56, 16'h0080 | 16'(r << 3) | 16'(r));
			rises = 0;
			setv(16'h1001);
			cyc(TDIV * 40);
			chk("restarts", 16'(r), 16'(rises));
			if (r > 1)
				chk("tickGap", 16'(1 << r), 16'(gap));
			setv(16'h0FFF);
			cyc(40);
			chkBit("retriesOff", 1'b0, outputEnable);
			clr(1'b1);
			cyc(3);
		end
		host.wr(8'h56, 16'h00B8);
		rises = 0;
		// fault lands one cycle before a tick: shortest one-unit count
		@(posedge unitTick);
		cyc(TDIV - 2);
		setv(16'h1001);
		cyc(TDIV * 40);
		chkBit("retryForever", 1'b1, rises > 7);
		outputOnCmd = 1'b0;
		setv(16'h0FFF);
		cyc(3);
		chkBit("cmdOff", 1'b0, outputEnable);
		outputOnCmd = 1'b1;
		host.wr(8'h56, 16'h0042);
		setv(16'h1001);
		cyc(12);
		chkBit("contRuns", 1'b1, outputEnable);
		cyc(60);
		chkBit("contThenOff", 1'b0, outputEnable);
		setv(16'h0FFF);
		clr(1'b1);
		setv(16'h1001);
		cyc(12);
		setv(16'h0FFF);
		cyc(60);
		chkBit("contRecovers", 1'b1, outputEnable);
		// clear in the very cycle of a fault: the new fault must win
		setv(16'h1001);
		clr(1'b1);
		chkBit("setWins", 1'b1, faultStatus);
		host.wr(8'h56, 16'h00C0);
		cyc(3);
		// mid-run reset clears a fault while the continue-response delay is still running
		rst_n = 1'b0;
		cyc(2);
		chkBit("rstOutOff", 1'b0, outputEnable);
		chkBit("rstStatus", 1'b0, faultStatus);
		setv(16'h0FFF);
		rst_n = 1'b1;
		cyc(4);
		chkBit("rstReleased", 1'b1, outputEnable);
		rdChk(8'h56, 16'h0080);
		completeRun();
	end
endmodule
